/* File: rtl/maie_pkg.sv */
// Shared constants and types for the mode-aware interrupt entry block.
// Assumes a 32-bit APB register bus and a 16-bit word-wide stack memory.
package maie_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_SYSCTL = 8'h00; // system_control_one
  localparam logic [7:0] OFS_CCR    = 8'h04; // condition_code_reg
  localparam logic [7:0] OFS_SP     = 8'h08; // stack_pointer
  localparam logic [7:0] OFS_FLAGS  = 8'h0C; // Request flags, write 1 clears
  localparam logic [7:0] OFS_ENABLE = 8'h10; // Per-source enables
  localparam logic [7:0] OFS_MODE   = 8'h14; // Mode and sequencer state
  localparam logic [7:0] OFS_ISTAT  = 8'h18; // Event status, write 1 clears
  localparam logic [7:0] OFS_IMASK  = 8'h1C; // Event mask

  // Control field positions in system_control_one
  localparam int BIT_SOFTWARE_STANDBY_FLAG  = 0; // software_standby_flag
  localparam int BIT_WSEL  = 1; // watch_select_bit
  localparam int BIT_DIRECT_TRANSFER_FLAG  = 2; // direct_transfer_flag
  localparam int BIT_LOW_SPEED_FLAG  = 3; // low_speed_flag
  localparam int SYSCTL_W  = 4;

  // Global mask position inside condition_code_reg
  localparam int CCR_I_BIT = 7;

  // Event status bits
  localparam int EV_WAKE  = 0; // Left a low-power mode
  localparam int EV_EXC   = 1; // Exception handler started
  localparam int EV_RTE   = 2; // Condition code restored
  localparam int EV_SLEEP = 3; // Entered a low-power mode
  localparam int EV_W     = 4;

  // Reset values
  localparam logic [7:0]  CCR_RST = 8'h80; // Masked out of reset
  localparam logic [15:0] SP_RST  = 16'h0000;
  localparam logic [15:0] WORD_STEP = 16'h0002; // One stacked word
  localparam logic [15:0] EVEN_MASK = 16'hFFFE; // Clears address bit 0
  localparam int MODE_SHIFT = 8; // Sequencer state field in OFS_MODE

  // System modes
  typedef enum logic [4:0] {
    MD_ACTIVE  = 5'h01,
    MD_SLEEP   = 5'h02,
    MD_STANDBY = 5'h04,
    MD_WATCH   = 5'h08,
    MD_SUBACT  = 5'h10
  } maie_mode_t;

  // Exception sequencer states
  typedef enum logic [4:0] {
    SQ_IDLE  = 5'h01,
    SQ_WAKE  = 5'h02,
    SQ_PUSH  = 5'h04,
    SQ_START = 5'h08,
    SQ_POP   = 5'h10
  } maie_seq_t;

  // Word-wide stack memory request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } maie_mem_req_t;

endpackage

/* File: rtl/maie_top.sv */
// Interrupt acceptance, power-mode wake-up and exception entry/return.
// Assumes a single pclk domain; sub_tick marks subclock edges in pclk time,
// and the stack memory answers each request with a one-cycle mem_ack.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module maie_top
  import maie_pkg::*;
#(
  parameter int          NSRC        = 8,
  parameter int          WAKE_CYCLES = 4,      // Oscillator settle before handler
  parameter logic [7:0]  ACC_ACTIVE  = 8'hFF,  // Sources accepted per mode
  parameter logic [7:0]  ACC_SLEEP   = 8'h07,
  parameter logic [7:0]  ACC_STANDBY = 8'h01,
  parameter logic [7:0]  ACC_WATCH   = 8'h03,
  parameter logic [7:0]  ACC_SUBACT  = 8'h03,
  parameter logic [7:0]  SUB_WAKE    = 8'h03   // Time base and irq0
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Interrupt sources and subclock
  input  wire logic [NSRC-1:0]    src_req,
  input  wire logic               sub_tick,
  // CPU core sequencer
  input  wire logic               sleep_exec,
  input  wire logic               rte_req,
  output logic                    exc_start,
  output logic [$clog2(NSRC)-1:0] exc_src,
  output logic                    cpu_run,
  output logic                    sub_clk_sel,
  // Stack memory
  output maie_mem_req_t           mem,
  input  wire logic               mem_ack,
  input  wire logic [15:0]        mem_rdata,
  // Interrupt line
  output logic                    irq
);

  localparam int SW = $clog2(NSRC);
  localparam int CW = $clog2(WAKE_CYCLES + 1);
  localparam logic [CW-1:0] WAKE_LOAD = CW'(WAKE_CYCLES - 1);

  // Core state
  maie_mode_t          mode, next_mode;        // Power mode
  maie_seq_t           seq, next_seq;          // Exception sequencer
  logic [7:0]          condition_code_reg, next_ccr;          // condition_code_reg
  logic [15:0]         sp, next_sp;            // stack_pointer
  logic [CW-1:0]       cnt, next_cnt;          // Wake delay
  logic [SW-1:0]       next_src;               // Source being served
  maie_mem_req_t       next_mem;               // Memory request
  // Configuration
  logic [SYSCTL_W-1:0] sysctl, next_sysctl;    // system_control_one
  logic [NSRC-1:0]     enable, next_enable;    // Source enables
  logic [EV_W-1:0]     imask, next_imask;      // Event mask
  // Flags and status
  logic [NSRC-1:0]     flags, next_flags;      // Request flags
  logic [EV_W-1:0]     istat, next_istat;      // Sticky events
  logic [EV_W-1:0]     ev;                     // Event pulses
  logic [31:0]         next_prdata;            // Read data
  // Decode
  logic                wr, rd_setup, mapped;
  logic [NSRC-1:0]     acc, pend;
  logic                take, low_power;
  logic [SW-1:0]       first_src;

  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = psel & penable;            // Zero wait states
  assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= OFS_IMASK);
  assign pslverr  = psel & penable & ~mapped;

  // Acceptance mask for the present mode
  always_comb begin
    case (mode)
      MD_ACTIVE:  acc = ACC_ACTIVE[NSRC-1:0];
      MD_SLEEP:   acc = ACC_SLEEP[NSRC-1:0];
      MD_STANDBY: acc = ACC_STANDBY[NSRC-1:0];
      MD_WATCH:   acc = ACC_WATCH[NSRC-1:0];
      MD_SUBACT:  acc = ACC_SUBACT[NSRC-1:0];
      default:    acc = '0;
    endcase
  end

  // Per-source request flags; set beats the software clear
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_flag
      logic set_i, clr_i;
      // Watch mode samples only on subclock ticks
      assign set_i = src_req[gi] & acc[gi] & ((mode != MD_WATCH) | sub_tick);
      assign clr_i = wr & (paddr == OFS_FLAGS) & pwdata[gi];
      assign next_flags[gi] = set_i | (flags[gi] & ~clr_i);
    end
  endgenerate

  // Gate by enable and global mask
  assign pend      = flags & enable;
  assign take      = (|pend) & ~condition_code_reg[CCR_I_BIT];
  assign low_power = (mode == MD_SLEEP) || (mode == MD_STANDBY) || (mode == MD_WATCH);
  assign cpu_run   = (mode == MD_ACTIVE) || (mode == MD_SUBACT);
  assign sub_clk_sel = (mode == MD_SUBACT);
  assign exc_start = (seq == SQ_START);

  // Lowest pending source wins
  always_comb begin
    first_src = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        first_src = SW'(i);
      end
    end
  end

  // Mode, sequencer, condition code and stack pointer
  always_comb begin
    next_mode = mode;
    next_seq  = seq;
    next_ccr  = condition_code_reg;
    next_sp   = sp;
    next_cnt  = cnt;
    next_src  = exc_src;
    next_mem  = mem;
    ev        = '0;
    // Software writes, overridden below by the sequencer
    if (wr && (paddr == OFS_CCR)) begin
      next_ccr = pwdata[7:0];
    end
    if (wr && (paddr == OFS_SP)) begin
      next_sp = pwdata[15:0];
    end
    case (seq)
      SQ_IDLE: begin
        if (take) begin
          next_src = first_src;
          if (low_power) begin
            next_seq = SQ_WAKE;                  // Wake first
            next_cnt = WAKE_LOAD;
          end else begin
            next_seq = SQ_PUSH;
            next_mem = '{req: 1'b1, we: 1'b1,    // Word write
                         addr: (sp - WORD_STEP) & EVEN_MASK,
                         wdata: {condition_code_reg, condition_code_reg}};     // Both bytes
          end
        end else if (rte_req && cpu_run) begin
          next_seq = SQ_POP;
          next_mem = '{req: 1'b1, we: 1'b0,      // Word read
                       addr: sp & EVEN_MASK,
                       wdata: 16'h0000};
        end else if (sleep_exec && cpu_run) begin
          ev[EV_SLEEP] = 1'b1;
          if (sysctl[BIT_DIRECT_TRANSFER_FLAG] && !sysctl[BIT_LOW_SPEED_FLAG]) begin
            next_mode = MD_WATCH;
          end else if (!sysctl[BIT_SOFTWARE_STANDBY_FLAG]) begin
            next_mode = MD_SLEEP;
          end else if (sysctl[BIT_WSEL]) begin
            next_mode = MD_WATCH;
          end else begin
            next_mode = MD_STANDBY;
          end
        end
      end
      SQ_WAKE: begin
        if (cnt == '0) begin
          ev[EV_WAKE] = 1'b1;
          // Low speed and a time base or irq0 source
          if ((mode == MD_WATCH) && sysctl[BIT_LOW_SPEED_FLAG] &&
              |(pend & SUB_WAKE[NSRC-1:0])) begin
            next_mode = MD_SUBACT;
          end else begin
            next_mode = MD_ACTIVE;
          end
          next_seq = SQ_PUSH;                    // Mode settled
          next_mem = '{req: 1'b1, we: 1'b1,
                       addr: (sp - WORD_STEP) & EVEN_MASK,
                       wdata: {condition_code_reg, condition_code_reg}};
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      SQ_PUSH: begin
        if (mem_ack) begin
          next_mem  = '0;
          next_sp   = sp - WORD_STEP;
          next_ccr  = condition_code_reg | (8'h01 << CCR_I_BIT); // Mask further entry
          next_seq  = SQ_START;
        end
      end
      SQ_START: begin
        ev[EV_EXC] = 1'b1;                       // Handler starts
        next_seq   = SQ_IDLE;
      end
      SQ_POP: begin
        if (mem_ack) begin
          next_mem   = '0;
          next_ccr   = mem_rdata[15:8];          // Even byte only
          next_sp    = sp + WORD_STEP;
          ev[EV_RTE] = 1'b1;
          next_seq   = SQ_IDLE;
        end
      end
      default: begin
        next_seq = SQ_IDLE;
        next_mem = '0;
      end
    endcase
  end

  // Configuration registers
  always_comb begin
    next_sysctl = sysctl;
    next_enable = enable;
    next_imask  = imask;
    if (wr && (paddr == OFS_SYSCTL)) begin
      next_sysctl = pwdata[SYSCTL_W-1:0];
    end
    if (wr && (paddr == OFS_ENABLE)) begin
      next_enable = pwdata[NSRC-1:0];
    end
    if (wr && (paddr == OFS_IMASK)) begin
      next_imask = pwdata[EV_W-1:0];
    end
  end

  // Sticky events; a new event wins over a write-one clear
  always_comb begin
    next_istat = istat;
    if (wr && (paddr == OFS_ISTAT)) begin
      next_istat = istat & ~pwdata[EV_W-1:0];
    end
    next_istat = next_istat | ev;
  end

  assign irq = |(istat & imask);

  // Read mux, captured in the setup cycle
  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      case (paddr)
        OFS_SYSCTL: next_prdata = 32'(sysctl);
        OFS_CCR:    next_prdata = 32'(condition_code_reg);
        OFS_SP:     next_prdata = 32'(sp);
        OFS_FLAGS:  next_prdata = 32'(flags);
        OFS_ENABLE: next_prdata = 32'(enable);
        OFS_MODE:   next_prdata = 32'(mode) | (32'(seq) << MODE_SHIFT);
        OFS_ISTAT:  next_prdata = 32'(istat);
        OFS_IMASK:  next_prdata = 32'(imask);
        default:    next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // All state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode    <= MD_ACTIVE;
      seq     <= SQ_IDLE;
      condition_code_reg     <= CCR_RST;
      sp      <= SP_RST;
      cnt     <= '0;
      exc_src <= '0;
      mem     <= '0;
      sysctl  <= '0;
      enable  <= '0;
      imask   <= '0;
      flags   <= '0;
      istat   <= '0;
      prdata  <= 32'h0000_0000;
    end else begin
      mode    <= next_mode;
      seq     <= next_seq;
      condition_code_reg     <= next_ccr;
      sp      <= next_sp;
      cnt     <= next_cnt;
      exc_src <= next_src;
      mem     <= next_mem;
      sysctl  <= next_sysctl;
      enable  <= next_enable;
      imask   <= next_imask;
      flags   <= next_flags;
      istat   <= next_istat;
      prdata  <= next_prdata;
    end
  end

endmodule // maie_top
`default_nettype wire

/* File: testbench/maie_props.sv */
// Concurrent checks on the stack port and the core handshakes of maie_top.
// Assumes one pclk domain and the one-cycle mem_ack of the stack memory.
`timescale 1ns/1ps
`default_nettype none
module maie_props
  import maie_pkg::*;
(
  // Clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // Bus handshake
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  // Stack port and core side
  input wire maie_mem_req_t mem,
  input wire logic          mem_ack,
  input wire logic          exc_start,
  input wire logic          cpu_run,
  input wire logic          sub_clk_sel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_addr_even: assert property (mem.req |-> !mem.addr[0])
    else $error("odd stack address");
  a_req_hold: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem.addr))
    else $error("stack request dropped early");
  a_push_pair: assert property (mem.req && mem.we |-> mem.wdata[15:8] == mem.wdata[7:0])
    else $error("saved bytes differ");
  a_exc_after_push: assert property (exc_start |-> $past(mem_ack) && $past(mem.we))
    else $error("handler without stacked word");
  a_exc_run: assert property (exc_start |-> cpu_run)
    else $error("handler while halted");
  a_exc_pulse: assert property (exc_start |=> !exc_start)
    else $error("handler start too long");
  a_sub_run: assert property (sub_clk_sel |-> cpu_run)
    else $error("subclock without running core");
  a_pop_quiet: assert property (mem.req && !mem.we |-> !exc_start)
    else $error("handler during restore");
  // Zero wait states on the register bus
  a_bus_ready: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
endmodule // maie_props
bind maie_top maie_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .mem(mem), .mem_ack(mem_ack),
  .exc_start(exc_start), .cpu_run(cpu_run), .sub_clk_sel(sub_clk_sel));
`default_nettype wire

/* File: testbench/maie_mem_model.sv */
// Word-wide stack memory that answers the block's stack requests.
// Assumes requests are held until acknowledged; slow adds three wait cycles.
`timescale 1ns/1ps
`default_nettype none
module maie_mem_model
  import maie_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          slow,
  input wire maie_mem_req_t mem,
  output logic              mem_ack,
  output logic [15:0]       mem_rdata
);
  logic [15:0] ram [0:255]; // Small window, bench may preload it
  logic [1:0]  wait_cnt;    // Wait cycles seen on this request
  // Plain always so the bench can also preload words
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_cnt  <= 2'h0;
    end else if (mem.req && !mem_ack && (!slow || wait_cnt == 2'h3)) begin
      mem_ack   <= 1'b1;
      wait_cnt  <= 2'h0;
      mem_rdata <= ram[mem.addr[8:1]];
      if (mem.we) begin
        ram[mem.addr[8:1]] <= mem.wdata;
      end
    end else begin
      // Data toggles off the answer cycle so stale reads show up
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= mem.req ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule // maie_mem_model
`default_nettype wire

/* File: testbench/maie_tb_top.sv */
// Self-checking bench for maie_top with a behavioural stack memory.
// Assumes zero-wait APB and a shortened wake count.
`timescale 1ns/1ps
`default_nettype none
module maie_tb_top;
  import maie_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]    paddr, src_req;
  logic [31:0]   pwdata, prdata, r;
  logic          perr;           // pslverr taken with the read data
  logic          sub_tick, sleep_exec, rte_req, exc_start, cpu_run;
  logic          sub_clk_sel, mem_ack, irq, slow;
  logic [2:0]    exc_src;
  logic [15:0]   mem_rdata;
  maie_mem_req_t mem;
  int            errors, samples_checked, exc_cnt;
  // Control bits, mode after sleep, mode after wake
  logic [3:0] sys_v [5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'hB};
  maie_mode_t slp_m [5] = '{MD_SLEEP, MD_STANDBY, MD_WATCH, MD_WATCH, MD_WATCH};
  maie_mode_t wak_m [5] = '{MD_ACTIVE, MD_ACTIVE, MD_ACTIVE, MD_ACTIVE, MD_SUBACT};

  maie_top #(.WAKE_CYCLES(3)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_req(src_req), .sub_tick(sub_tick),
    .sleep_exec(sleep_exec), .rte_req(rte_req), .exc_start(exc_start), .exc_src(exc_src),
    .cpu_run(cpu_run), .sub_clk_sel(sub_clk_sel), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .irq(irq));
  maie_mem_model u_mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Handler starts seen so far
  always @(posedge pclk) begin
    if (exc_start === 1'b1) exc_cnt <= exc_cnt + 1;
  end
  // Hang guard, far beyond the expected run
  initial begin
    #(20000 * 25);
    errors++;
    stop_test();
  end

  function automatic logic [31:0] mv(input maie_mode_t m);
    return {19'h0, SQ_IDLE, 3'h0, m};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    perr = pslverr;
    if (n >= 20) errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // One-cycle pulses on the source and core inputs
  task automatic pulse(input logic [7:0] s, input logic t, input logic sl, input logic rt);
    @(posedge pclk);
    src_req    <= s;
    sub_tick   <= t;
    sleep_exec <= sl;
    rte_req    <= rt;
    @(posedge pclk);
    src_req    <= 8'h00;
    sub_tick   <= 1'b0;
    sleep_exec <= 1'b0;
    rte_req    <= 1'b0;
  endtask
  // Wait for handler start (x=1) or memory answer (x=0)
  task automatic waitc(input logic x);
    int n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((x ? exc_start : mem_ack) !== 1'b1 && n < 300);
    if (n >= 300) errors++;
  endtask
  task automatic chkirq(input logic e);
    @(negedge pclk);
    chk(irq, e);
  endtask
  task automatic stop_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, sub_tick, sleep_exec, rte_req, slow} = '0;
    {paddr, src_req, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CCR, 32'h80);
    chk(perr, 1'b0);
    apb(1'b1, OFS_MODE, 32'h0);
    rd(OFS_MODE, mv(MD_ACTIVE));
    rd(8'h20, 32'h0);
    chk(perr, 1'b1);
    // Entry from active with an odd stack pointer
    apb(1'b1, OFS_IMASK, 32'h2);
    apb(1'b1, OFS_ENABLE, 32'h5);
    apb(1'b1, OFS_SP, 32'h41);
    apb(1'b1, OFS_CCR, 32'h25);
    pulse(8'h04, 1'b0, 1'b0, 1'b0);
    waitc(1'b1);
    chk(exc_src, 32'h2);
    rd(OFS_SP, 32'h3F);
    rd(OFS_CCR, 32'hA5);
    chk(u_mem.ram[8'h1F], 32'h2525);
    chkirq(1'b1);
    apb(1'b1, OFS_IMASK, 32'h0);
    chkirq(1'b0);
    apb(1'b1, OFS_IMASK, 32'h2);
    apb(1'b1, OFS_ISTAT, 32'h2);
    chkirq(1'b0);
    // Masked by the global flag: flag set anew, no second entry
    apb(1'b1, OFS_FLAGS, 32'hFF);
    pulse(8'h04, 1'b0, 1'b0, 1'b0);
    rd(OFS_FLAGS, 32'h4);
    chk(exc_cnt, 32'h1);
    apb(1'b1, OFS_FLAGS, 32'hFF);
    // Restore from a word whose bytes differ, slow memory
    slow <= 1'b1;
    u_mem.ram[8'h1F] = 16'h4A13;
    pulse(8'h00, 1'b0, 1'b0, 1'b1);
    waitc(1'b0);
    rd(OFS_CCR, 32'h4A);
    rd(OFS_SP, 32'h41);
    // Every sleep decode, refusal and wake path
    for (int i = 0; i < 5; i++) begin
      // Flags first: an old flag must not enter once the mask drops
      apb(1'b1, OFS_FLAGS, 32'hFF);
      apb(1'b1, OFS_CCR, 32'h0);
      apb(1'b1, OFS_SYSCTL, {28'h0, sys_v[i]});
      pulse(8'h00, 1'b0, 1'b1, 1'b0);
      rd(OFS_MODE, mv(slp_m[i]));
      chk(cpu_run, 1'b0);
      pulse(8'h80, 1'b1, 1'b0, 1'b0);
      rd(OFS_FLAGS, 32'h0);
      rd(OFS_MODE, mv(slp_m[i]));
      if (slp_m[i] == MD_WATCH) begin
        pulse(8'h01, 1'b0, 1'b0, 1'b0);
        rd(OFS_FLAGS, 32'h0);
      end
      pulse(8'h01, 1'b1, 1'b0, 1'b0);
      waitc(1'b1);
      rd(OFS_MODE, mv(wak_m[i]));
      chk(cpu_run, 1'b1);
      chk(exc_src, 32'h0);
      chk(sub_clk_sel, wak_m[i] == MD_SUBACT);
    end
    chk(exc_cnt, 32'h6);
    stop_test();
  end
endmodule // maie_tb_top
`default_nettype wire
